/* srw_supervisor.sv */
/*
 reset supervisor: combines undervoltage, manual reset and dual-mode
 watchdog into stretched reset outputs, plus an unstretched power-fail
 warning. assumes comparator results arrive as asynchronous levels.
*/
`timescale 1ns/1ps
module srw_supervisor
   import srw_pkg::*;
#(
   parameter longint RESET_TIMEOUT = srw_pkg::RESET_TIMEOUT_CYC,
   parameter longint WD_LONG = srw_pkg::WD_LONG_CYC,
   parameter longint WD_NORMAL = srw_pkg::WD_NORMAL_CYC,
   parameter longint DEBOUNCE = srw_pkg::DEBOUNCE_CYC
) (
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   input wire srw_pkg::srw_inputs_type i_pins,
   input wire logic i_wd_disable,
   output logic o_first_reset_out_n,
   output logic o_second_reset_out_n,
   output logic o_reset_out,
   output logic o_powerfail_warn_n
);
   import srw_pkg::*;

   localparam logic [CNT_W-1:0] RST_TERM = CNT_W'(RESET_TIMEOUT - 1);
   localparam logic [CNT_W-1:0] LONG_TERM = CNT_W'(WD_LONG - 1);
   localparam logic [CNT_W-1:0] NORM_TERM = CNT_W'(WD_NORMAL - 1);
   localparam logic [CNT_W-1:0] DEB_TERM = CNT_W'(DEBOUNCE - 1);
   localparam logic [CNT_W-1:0] CNT_ZERO = 32'h0000_0000;
   localparam logic [CNT_W-1:0] CNT_ONE = 32'h0000_0001;
   localparam longint CNT_LIMIT = longint'(1) << CNT_W;

   // every terminal count must fit the CNT_W-bit counters
   if (RESET_TIMEOUT < 1 || WD_LONG < 2 || WD_NORMAL < 2 || DEBOUNCE < 1)
   begin : g_count_small
      $error("srw_supervisor: counts too small");
   end
   if (WD_LONG > CNT_LIMIT || WD_NORMAL > CNT_LIMIT || RESET_TIMEOUT > CNT_LIMIT
       || DEBOUNCE > CNT_LIMIT)
   begin : g_count_wide
      $error("srw_supervisor: counts exceed counter width");
   end

   // >= so a counter can never run past its end and wrap
   function automatic logic at_term(input logic [CNT_W-1:0] cnt,
                                    input logic [CNT_W-1:0] term);
      at_term = (cnt >= term);
   endfunction : at_term

   srw_inputs_type pins_s;
   logic wd_prev;
   logic mr_low;
   logic [CNT_W-1:0] deb_cnt;
   logic uv_cause;
   logic cause;
   logic rst_active;
   logic [CNT_W-1:0] rst_cnt;
   srw_wd_mode_type wd_mode;
   logic [CNT_W-1:0] wd_cnt;
   logic wd_edge;
   logic wd_expire;
   logic wd_fire;

   // safe idle levels: supplies good, pins high, kick low
   srw_sync #(
      .WIDTH(IN_W),
      .STAGES(SYNC_STAGES),
      .RESET_VALUE(SYNC_IDLE)
   ) u_sync (
      .i_core_clk(i_core_clk),
      .i_rst_n(i_rst_n),
      .i_async(i_pins),
      .o_sync(pins_s)
   );

   // manual reset debounce: a low must stand DEBOUNCE cycles to count,
   // release is taken at once so a bounce on release just reopens a press
   always_ff @(posedge i_core_clk)
   begin
      if (!i_rst_n)
      begin
         deb_cnt <= CNT_ZERO;
         mr_low <= 1'b0;
      end
      else if (pins_s.manual_reset_n)
      begin
         deb_cnt <= CNT_ZERO;
         mr_low <= 1'b0;
      end
      else if (at_term(deb_cnt, DEB_TERM))
         mr_low <= 1'b1;
      else
         deb_cnt <= deb_cnt + CNT_ONE;
   end

   assign uv_cause = !pins_s.primary_supply_ok || !pins_s.secondary_supply_ok
                     || !pins_s.aux_monitor_in;
   assign cause = uv_cause || mr_low || wd_fire;

   // stretch counter; any live cause pins it at zero
   always_ff @(posedge i_core_clk)
   begin
      if (!i_rst_n)
      begin
         rst_active <= 1'b1;
         rst_cnt <= CNT_ZERO;
      end
      else if (cause)
      begin
         rst_active <= 1'b1;
         rst_cnt <= CNT_ZERO;
      end
      else if (rst_active)
      begin
         if (at_term(rst_cnt, RST_TERM))
            rst_active <= 1'b0;
         else
            rst_cnt <= rst_cnt + CNT_ONE;
      end
   end

   assign o_first_reset_out_n = !rst_active;
   assign o_second_reset_out_n = !rst_active;
   assign o_reset_out = rst_active;

   // watchdog
   always_ff @(posedge i_core_clk)
   begin
      if (!i_rst_n)
         wd_prev <= SYNC_IDLE.wd_kick_in;
      else
         wd_prev <= pins_s.wd_kick_in;
   end

   assign wd_edge = (pins_s.wd_kick_in != wd_prev);
   assign wd_expire = (wd_mode == SRW_WD_LONG && at_term(wd_cnt, LONG_TERM))
                      || (wd_mode == SRW_WD_NORMAL && at_term(wd_cnt, NORM_TERM));
   assign wd_fire = wd_expire && !i_wd_disable;

   // reset held: park in long mode with a cleared count, so every reset
   // event (supply, manual, watchdog) restarts the long boot allowance
   always_ff @(posedge i_core_clk)
   begin
      if (!i_rst_n)
      begin
         wd_mode <= SRW_WD_OFF;
         wd_cnt <= CNT_ZERO;
      end
      else if (i_wd_disable)
      begin
         wd_mode <= SRW_WD_OFF;
         wd_cnt <= CNT_ZERO;
      end
      else if (rst_active)
      begin
         wd_mode <= SRW_WD_LONG;
         wd_cnt <= CNT_ZERO;
      end
      else
      begin
         case (wd_mode)
            SRW_WD_OFF:
            begin
               wd_mode <= SRW_WD_LONG;
               wd_cnt <= CNT_ZERO;
            end
            SRW_WD_LONG, SRW_WD_NORMAL:
            begin
               if (wd_edge)
               begin
                  wd_mode <= SRW_WD_NORMAL;
                  wd_cnt <= CNT_ZERO;
               end
               else if (!wd_expire)
                  wd_cnt <= wd_cnt + CNT_ONE;
            end
            default:
            begin
               wd_mode <= SRW_WD_LONG;
               wd_cnt <= CNT_ZERO;
            end
         endcase
      end
   end

   // registered so the warning is a clean flop output
   always_ff @(posedge i_core_clk)
   begin
      if (!i_rst_n)
         o_powerfail_warn_n <= 1'b1;
      else
         o_powerfail_warn_n <= pins_s.powerfail_sense_in;
   end

   property p_uv_asserts;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      uv_cause |=> rst_active;
   endproperty
   a_uv_asserts: assert property (p_uv_asserts)
      else $error("undervoltage did not assert reset");

   property p_stretch;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      $fell(cause) |-> rst_active && rst_cnt == CNT_ZERO;
   endproperty
   a_stretch: assert property (p_stretch)
      else $error("reset stretch did not start at zero");

   property p_restart;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (rst_active && rst_cnt != CNT_ZERO && uv_cause) |=> rst_cnt == CNT_ZERO;
   endproperty
   a_restart: assert property (p_restart)
      else $error("timeout did not restart");

   property p_release;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      $fell(rst_active) |-> $past(rst_cnt) == RST_TERM;
   endproperty
   a_release: assert property (p_release)
      else $error("reset released early");

   property p_mr_hold;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      mr_low |=> rst_active;
   endproperty
   a_mr_hold: assert property (p_mr_hold)
      else $error("manual reset not held");

   property p_debounce;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      $rose(mr_low) |-> $past(!pins_s.manual_reset_n)
         && $past(deb_cnt) == DEB_TERM;
   endproperty
   a_debounce: assert property (p_debounce)
      else $error("manual reset taken without stable low");

   property p_polarity;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      o_reset_out != o_first_reset_out_n && o_first_reset_out_n == o_second_reset_out_n;
   endproperty
   a_polarity: assert property (p_polarity)
      else $error("reset outputs disagree");

   property p_wd_fire;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      // the watchdog block only sees the raised reset one edge later
      wd_fire |=> rst_active ##1 (wd_mode == SRW_WD_LONG && wd_cnt == CNT_ZERO);
   endproperty
   a_wd_fire: assert property (p_wd_fire)
      else $error("watchdog expiry did not reset");

   property p_wd_disable;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      i_wd_disable |=> wd_mode == SRW_WD_OFF && !wd_fire;
   endproperty
   a_wd_disable: assert property (p_wd_disable)
      else $error("disabled watchdog fired");

   property p_wd_normal;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (wd_mode == SRW_WD_LONG && wd_edge && !rst_active && !i_wd_disable)
         |=> wd_mode == SRW_WD_NORMAL && wd_cnt == CNT_ZERO;
   endproperty
   a_wd_normal: assert property (p_wd_normal)
      else $error("first kick did not enter normal mode");

   property p_pfo;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      ##1 o_powerfail_warn_n == $past(pins_s.powerfail_sense_in);
   endproperty
   a_pfo: assert property (p_pfo)
      else $error("power-fail output not following input");

   c_uv_cycle: cover property (@(posedge i_core_clk) disable iff (!i_rst_n)
      $fell(rst_active) ##[1:20] uv_cause);
   c_mr_press: cover property (@(posedge i_core_clk) disable iff (!i_rst_n)
      $rose(mr_low));
   c_wd_normal: cover property (@(posedge i_core_clk) disable iff (!i_rst_n)
      $rose(wd_mode == SRW_WD_NORMAL));
   c_wd_fire: cover property (@(posedge i_core_clk) disable iff (!i_rst_n)
      wd_fire);
   c_restart: cover property (@(posedge i_core_clk) disable iff (!i_rst_n)
      rst_active && rst_cnt != CNT_ZERO && uv_cause);

endmodule : srw_supervisor

/* srw_pkg.sv */
/*
 package for the supply/reset/watchdog supervisor: timing figures,
 derived cycle counts, debounce default, state and carrier types.
 assumes a 100 MHz core clock.
*/
package srw_pkg;

   localparam int CLK_MHZ = 100;
   // reset timeout, chosen from the selectable range, in microseconds
   localparam int RESET_TIMEOUT_US = 1120;
   localparam int WD_LONG_S = 35;
   localparam int WD_NORMAL_MS = 1120;
   localparam int DEBOUNCE_US = 1000;
   localparam int SYNC_STAGES = 2;
   localparam int CNT_W = 32;

   localparam longint RESET_TIMEOUT_CYC = longint'(RESET_TIMEOUT_US) * CLK_MHZ;
   localparam longint WD_LONG_CYC = longint'(WD_LONG_S) * 1000000 * CLK_MHZ;
   localparam longint WD_NORMAL_CYC = longint'(WD_NORMAL_MS) * 1000 * CLK_MHZ;
   localparam longint DEBOUNCE_CYC = longint'(DEBOUNCE_US) * CLK_MHZ;

   typedef enum logic [1:0] {
      SRW_WD_OFF,
      SRW_WD_LONG,
      SRW_WD_NORMAL
   } srw_wd_mode_type;

   // raw comparator and pin levels, all treated as asynchronous
   typedef struct packed {
      logic primary_supply_ok;
      logic secondary_supply_ok;
      logic aux_monitor_in;
      logic powerfail_sense_in;
      logic manual_reset_n;
      logic wd_kick_in;
   } srw_inputs_type;

   // synchroniser reset levels: supplies and references good, no press, kick low
   localparam srw_inputs_type SYNC_IDLE = '{
      primary_supply_ok: 1'b1,
      secondary_supply_ok: 1'b1,
      aux_monitor_in: 1'b1,
      powerfail_sense_in: 1'b1,
      manual_reset_n: 1'b1,
      wd_kick_in: 1'b0
   };

   localparam int IN_W = $bits(srw_inputs_type);

endpackage : srw_pkg

/* srw_sync.sv */
/*
 multi-stage synchroniser for a vector of asynchronous levels.
 assumes a single clock; the output is the last stage only.
*/
`timescale 1ns/1ps
module srw_sync #(
   parameter int WIDTH = 6,
   parameter int STAGES = 2,
   parameter logic [WIDTH-1:0] RESET_VALUE = '1
) (
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   input wire logic [WIDTH-1:0] i_async,
   output logic [WIDTH-1:0] o_sync
);

   logic [WIDTH-1:0] stage [STAGES];

   if (STAGES < 2)
   begin : g_stages_check
      $error("srw_sync needs at least two stages");
   end

   always_ff @(posedge i_core_clk)
   begin
      if (!i_rst_n)
      begin
         for (int k = 0; k < STAGES; k++)
            stage[k] <= RESET_VALUE;
      end
      else
      begin
         stage[0] <= i_async;
         for (int k = 1; k < STAGES; k++)
            stage[k] <= stage[k-1];
      end
   end

   assign o_sync = stage[STAGES-1];

endmodule : srw_sync

/* srw_proc_model.sv */
/*
 processor model: toggles the watchdog kick line at a fixed spacing.
 assumes the supervisor's active-low reset as its own reset.
*/
`timescale 1ns/1ps
module srw_proc_model #(
   parameter int KICK = 20
) (
   input wire logic i_core_clk,
   input wire logic i_reset_n,
   input wire logic i_kick_en,
   output logic o_wd_kick_in
);
   int cnt = 0;
   // a stalled processor holds its last kick level; reset returns it low
   always @(posedge i_core_clk)
   begin
      if (!i_reset_n)
      begin
         cnt <= 0;
         o_wd_kick_in <= #1 1'b0;
      end
      else if (i_kick_en && cnt >= KICK - 1)
      begin
         cnt <= 0;
         o_wd_kick_in <= #1 ~o_wd_kick_in;
      end
      else if (i_kick_en)
         cnt <= cnt + 1;
   end
endmodule : srw_proc_model

/* testbench.sv */
/*
 testbench: undervoltage, manual, power-fail and watchdog scenarios.
 assumes short timing parameters so each scenario stays brief.
*/
`timescale 1ns/1ps
module testbench;
   import srw_pkg::*;
   localparam int RT = 20;
   localparam int WL = 200;
   localparam int WN = 50;
   localparam int DB = 5;
   logic i_core_clk = 1'b0;
   logic i_rst_n = 1'b0;
   logic i_wd_disable = 1'b1;
   logic kick_en = 1'b0;
   logic [5:0] p = 6'h3e;
   logic kick;
   srw_inputs_type pins;
   logic first_reset_out_n_n, second_reset_out_n_n, rst_hi, pf_n;
   int fails = 0;
   int n_tests = 0;
   always #5 i_core_clk = ~i_core_clk;
   always_comb
   begin
      pins = p;
      pins.wd_kick_in = kick;
   end
   srw_supervisor #(.RESET_TIMEOUT(RT), .WD_LONG(WL), .WD_NORMAL(WN), .DEBOUNCE(DB)) u_dut (
      .i_core_clk(i_core_clk),
      .i_rst_n(i_rst_n),
      .i_pins(pins),
      .i_wd_disable(i_wd_disable),
      .o_first_reset_out_n(first_reset_out_n_n),
      .o_second_reset_out_n(second_reset_out_n_n),
      .o_reset_out(rst_hi),
      .o_powerfail_warn_n(pf_n)
   );
   srw_proc_model #(.KICK(20)) u_proc (
      .i_core_clk(i_core_clk),
      .i_reset_n(first_reset_out_n_n),
      .i_kick_en(kick_en),
      .o_wd_kick_in(kick)
   );
   task automatic results;
      $display("fails %0d n_tests %0d", fails, n_tests);
      if (fails == 0 && n_tests > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : results
   task automatic chk(input logic got, input logic exp);
      n_tests++;
      if (got !== exp)
      begin
         fails++;
         $display("[ERR] %0t level %b expected %b", $time, got, exp);
      end
   endtask : chk
   task automatic chk_rst(input logic exp);
      chk(rst_hi, exp);
      chk(first_reset_out_n_n, ~exp);
      chk(second_reset_out_n_n, ~exp);
   endtask : chk_rst
   task automatic cyc(input int n);
      repeat (n) @(posedge i_core_clk);
      #1;
   endtask : cyc
   // bounded wait; a missed level ends the run
   task automatic wait_rst(input logic exp, input int lim);
      int i;
      i = 0;
      while (rst_hi !== exp && i < lim)
      begin
         cyc(1);
         i++;
      end
      chk_rst(exp);
      if (rst_hi !== exp)
         results();
   endtask : wait_rst
   task automatic hold(input int n, input logic exp);
      repeat (n)
      begin
         cyc(1);
         chk_rst(exp);
      end
   endtask : hold
   task automatic t_uv;
      for (int i = 5; i >= 3; i--)
      begin
         p[i] = 1'b0;
         cyc(3);
         chk_rst(1'b1);
         p[i] = 1'b1;
         cyc(RT);
         chk_rst(1'b1);
         wait_rst(1'b0, 6);
      end
   endtask : t_uv
   task automatic t_restart;
      p[5] = 1'b0;
      cyc(4);
      p[5] = 1'b1;
      cyc(RT / 2);
      p[5] = 1'b0;
      cyc(3);
      p[5] = 1'b1;
      cyc(RT);
      chk_rst(1'b1);
      wait_rst(1'b0, 6);
   endtask : t_restart
   task automatic t_manual;
      repeat (3)
      begin
         p[1] = 1'b0;
         cyc(DB - 3);
         p[1] = 1'b1;
         cyc(1);
      end
      hold(8, 1'b0);
      p[1] = 1'b0;
      cyc(DB + 4);
      chk_rst(1'b1);
      hold(10, 1'b1);
      p[1] = 1'b1;
      cyc(RT);
      chk_rst(1'b1);
      wait_rst(1'b0, 6);
   endtask : t_manual
   task automatic t_pf;
      p[2] = 1'b0;
      cyc(2);
      chk(pf_n, 1'b1);
      cyc(1);
      chk(pf_n, 1'b0);
      chk_rst(1'b0);
      p[2] = 1'b1;
      cyc(3);
      chk(pf_n, 1'b1);
   endtask : t_pf
   task automatic t_wd;
      i_wd_disable = 1'b0;
      kick_en = 1'b1;
      hold(WL + 100, 1'b0);
      kick_en = 1'b0;
      wait_rst(1'b1, WN + 10);
      hold(RT - 1, 1'b1);
      wait_rst(1'b0, 6);
      hold(WN + 30, 1'b0);
      wait_rst(1'b1, WL);
      hold(RT - 1, 1'b1);
      wait_rst(1'b0, 6);
      i_wd_disable = 1'b1;
      hold(WL + 50, 1'b0);
   endtask : t_wd
   initial
   begin
      cyc(20);
      i_rst_n = 1'b1;
      wait_rst(1'b0, RT + 10);
      t_uv();
      t_restart();
      t_manual();
      t_pf();
      t_wd();
      results();
   end
endmodule : testbench
